// File: bga_arbiter.v
// gap timing and arbitration engine of a backplane node, with apb registers
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "bga_regs.vh"

module bga_arbiter #(
   parameter ID_BITS = 6,
   parameter ARB_DIV = 1
) (
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire rx_data_i,
   input wire rx_strb_i,
   output reg tx_data_o,
   output reg tx_data_oe_n_o,
   output reg bus_won_o
);

   // ----------------------------------------------------------------
   // states and derived constants
   // ----------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_WAIT = 2'h1;
   localparam [1:0] ST_ARB = 2'h2;
   localparam [1:0] ST_OWN = 2'h3;
   localparam integer DIV_CNT = ARB_DIV - 1;
   localparam [7:0] DIV_LAST = DIV_CNT[7:0]; // divider counts in 8 bits
   localparam [5:0] ID_LOW = (6'h01 << (6 - ID_BITS)) - 6'h01;
   localparam [5:0] ID_MASK = ~ID_LOW;

   reg [7:0] div_q;
   reg tick_q;
   reg [5:0] idle_q;
   reg [1:0] st_q;
   reg [1:0] kind_q;
   reg concat_q;
   reg [5:0] thr_q;
   reg [9:0] sh_q;
   reg [3:0] bit_q;
   reg permit_q;
   reg [5:0] nid_q;
   reg [3:0] uprio_q;
   reg won_q;
   reg lost_q;
   reg aband_q;
   reg refuse_q;
   reg [31:0] rd_d;
   reg hit_d;
   reg [3:0] prio_d;

   wire bus_busy;
   wire step;
   wire [5:0] idle_inc;
   wire go;
   wire loss;
   wire win;
   wire arst_hit;
   wire acc;
   wire wr_en;
   wire wr_ctrl;
   wire wr_cmd;
   wire wr_stat;
   wire cmd_start;
   wire cmd_rel;
   wire cmd_cancel;
   wire [1:0] cmd_kind;
   wire [9:0] seq_d;
   wire [31:0] stat_w;

   // ----------------------------------------------------------------
   // arbitration clock enable
   // ----------------------------------------------------------------
   // one-cycle tick per arbitration clock period
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_q <= 8'h00;
         tick_q <= 1'b0;
      end else if (div_q == DIV_LAST) begin
         div_q <= 8'h00;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 8'h01;
         tick_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // gap timing
   // ----------------------------------------------------------------
   // any asserted receive line means the bus is busy
   assign bus_busy = rx_data_i | rx_strb_i;
   assign step = tick_q & ~bus_busy & (idle_q != `BGA_ARST_DRV);
   assign idle_inc = idle_q + 6'h01;

   // idle counter saturates at the longest drive point
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         idle_q <= 6'h00;
      end else if (bus_busy) begin
         idle_q <= 6'h00;
      end else if (step) begin
         idle_q <= idle_inc;
      end
   end

   // the moment the arbitration reset gap is reached
   assign arst_hit = step & (idle_inc == `BGA_ARST_DET);

   // drive point of the gap being waited for
   assign go = (st_q == ST_WAIT) & step & (idle_inc == thr_q);

   // drive point for a request kind; fair without permit waits longest
   function [5:0] thr_of;
      input [1:0] k;
      input p;
      begin
         case (k)
            `BGA_KIND_ACK: thr_of = `BGA_ACK_DRV;
            `BGA_KIND_FAIR: begin
               if (p) begin
                  thr_of = `BGA_SUB_DRV;
               end else begin
                  thr_of = `BGA_ARST_DRV;
               end
            end
            default: thr_of = `BGA_SUB_DRV;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // arbitration sequence
   // ----------------------------------------------------------------
   // priority picked when a contest starts, reserved codes kept apart
   always @* begin
      case (kind_q)
         `BGA_KIND_FAIR: prio_d = `BGA_PRIO_FAIR;
         `BGA_KIND_CYC: prio_d = `BGA_PRIO_CYC;
         default: begin
            if (uprio_q == `BGA_PRIO_FAIR) begin
               prio_d = 4'h1;
            end else if (uprio_q == `BGA_PRIO_CYC) begin
               prio_d = 4'he;
            end else begin
               prio_d = uprio_q;
            end
         end
      endcase
   end

   // priority then number; unused low id bits go out as zero
   assign seq_d = {prio_d, nid_q & ID_MASK};

   // our zero bit met by an asserted bus means a stronger node
   assign loss = (st_q == ST_ARB) & tick_q & ~sh_q[9] & rx_data_i;
   assign win = (st_q == ST_ARB) & tick_q & ~loss & (bit_q == `BGA_SEQ_LAST);

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   assign acc = psel_i & penable_i;
   assign wr_en = acc & pwrite_i & pready_o;
   assign wr_ctrl = wr_en & (paddr_i == `BGA_CTRL_OFF);
   assign wr_cmd = wr_en & (paddr_i == `BGA_CMD_OFF);
   assign wr_stat = wr_en & (paddr_i == `BGA_STAT_OFF);
   assign cmd_start = wr_cmd & pwdata_i[`BGA_CMD_START];
   assign cmd_rel = wr_cmd & pwdata_i[`BGA_CMD_RELEASE];
   assign cmd_cancel = wr_cmd & pwdata_i[`BGA_CMD_CANCEL];
   assign cmd_kind = pwdata_i[`BGA_CMD_KIND_LSB +: 2];

   // status word
   assign stat_w = {21'h000000, st_q,
                    idle_q >= `BGA_ARST_DET,
                    idle_q >= `BGA_SUB_DET,
                    idle_q >= `BGA_ACK_DET,
                    refuse_q, aband_q, lost_q, won_q,
                    st_q != ST_IDLE, permit_q};

   // read mux and address decode
   always @* begin
      rd_d = 32'h00000000;
      hit_d = 1'b1;
      case (paddr_i)
         `BGA_CTRL_OFF: rd_d = {22'h000000, uprio_q, nid_q};
         `BGA_CMD_OFF: rd_d = {27'h0000000, concat_q, 2'h0, kind_q};
         `BGA_STAT_OFF: rd_d = stat_w;
         `BGA_IDLE_OFF: rd_d = {26'h0000000, idle_q};
         default: hit_d = 1'b0;
      endcase
   end

   // one wait state: data captured, then pready for one cycle
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h00000000;
      end else if (acc && !pready_o) begin
         pready_o <= 1'b1;
         pslverr_o <= ~hit_d;
         prdata_o <= pwrite_i ? 32'h00000000 : rd_d;
      end else begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

   // node identifier and urgent priority, software written
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         nid_q <= `BGA_NID_RST;
         uprio_q <= `BGA_PRIO_RST;
      end else if (wr_ctrl) begin
         nid_q <= pwdata_i[`BGA_CTRL_NID_LSB +: 6];
         uprio_q <= pwdata_i[`BGA_CTRL_PRIO_LSB +: 4];
      end
   end

   // ----------------------------------------------------------------
   // fairness permit
   // ----------------------------------------------------------------
   // set at each new fairness interval; a set beats a clear
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         permit_q <= `BGA_PERMIT_RST;
      end else if (arst_hit) begin
         permit_q <= 1'b1;
      end else if (win && kind_q == `BGA_KIND_FAIR && !concat_q) begin
         permit_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // sticky status flags, write one to clear, event wins
   // ----------------------------------------------------------------
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         won_q <= 1'b0;
         lost_q <= 1'b0;
         aband_q <= 1'b0;
         refuse_q <= 1'b0;
      end else begin
         won_q <= win | (won_q & ~(wr_stat & pwdata_i[`BGA_ST_WON]));
         lost_q <= loss | (lost_q & ~(wr_stat & pwdata_i[`BGA_ST_LOST]));
         aband_q <= ((st_q == ST_WAIT) & bus_busy & (idle_q != 6'h00))
                    | (aband_q & ~(wr_stat & pwdata_i[`BGA_ST_ABAND]));
         refuse_q <= (cmd_start & (st_q != ST_IDLE))
                     | (refuse_q & ~(wr_stat & pwdata_i[`BGA_ST_REFUSE]));
      end
   end

   // ----------------------------------------------------------------
   // request and arbitration state machine
   // ----------------------------------------------------------------
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= ST_IDLE;
         kind_q <= `BGA_KIND_FAIR;
         concat_q <= 1'b0;
         thr_q <= `BGA_SUB_DRV;
         sh_q <= 10'h000;
         bit_q <= 4'h0;
         tx_data_o <= 1'b0;
         tx_data_oe_n_o <= 1'b1;
         bus_won_o <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               // a link request starts the wait for its gap
               if (cmd_start) begin
                  st_q <= ST_WAIT;
                  kind_q <= cmd_kind;
                  concat_q <= pwdata_i[`BGA_CMD_CONCAT];
                  thr_q <= thr_of(cmd_kind, permit_q);
               end
            end
            ST_WAIT: begin
               if (cmd_cancel) begin
                  st_q <= ST_IDLE;
               end else if (bus_busy) begin
                  // opportunity lost; wait again for a fresh gap
                  thr_q <= thr_of(kind_q, permit_q);
               end else if (go && kind_q == `BGA_KIND_ACK) begin
                  // acknowledge takes the bus without a contest
                  st_q <= ST_OWN;
                  tx_data_o <= 1'b1;
                  tx_data_oe_n_o <= 1'b0;
                  bus_won_o <= 1'b1;
               end else if (go) begin
                  // first sequence bit goes out as the gap completes
                  st_q <= ST_ARB;
                  sh_q <= seq_d;
                  bit_q <= 4'h0;
                  tx_data_o <= seq_d[9];
                  tx_data_oe_n_o <= ~seq_d[9];
               end
            end
            ST_ARB: begin
               if (loss) begin
                  // release for the rest of this contest
                  st_q <= ST_WAIT;
                  thr_q <= thr_of(kind_q, permit_q);
                  tx_data_o <= 1'b0;
                  tx_data_oe_n_o <= 1'b1;
               end else if (win) begin
                  // last bit survived: we own the bus
                  st_q <= ST_OWN;
                  tx_data_o <= 1'b1;
                  tx_data_oe_n_o <= 1'b0;
                  bus_won_o <= 1'b1;
               end else if (tick_q) begin
                  // one bit per arbitration clock, msb first
                  sh_q <= {sh_q[8:0], 1'b0};
                  bit_q <= bit_q + 4'h1;
                  tx_data_o <= sh_q[8];
                  tx_data_oe_n_o <= ~sh_q[8];
               end
            end
            ST_OWN: begin
               // hold the bus asserted until the link lets go
               if (cmd_rel) begin
                  st_q <= ST_IDLE;
                  tx_data_o <= 1'b0;
                  tx_data_oe_n_o <= 1'b1;
                  bus_won_o <= 1'b0;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // bga_arbiter
`default_nettype wire

// File: bga_regs.vh
// register map, field positions, reset values and gap counts of the arbiter
`ifndef BGA_REGS_VH
`define BGA_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BGA_CTRL_OFF 8'h00
`define BGA_CMD_OFF 8'h04
`define BGA_STAT_OFF 8'h08
`define BGA_IDLE_OFF 8'h0c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BGA_CTRL_NID_LSB 0
`define BGA_CTRL_PRIO_LSB 6
`define BGA_CMD_KIND_LSB 0
`define BGA_CMD_START 2
`define BGA_CMD_RELEASE 3
`define BGA_CMD_CONCAT 4
`define BGA_CMD_CANCEL 5
`define BGA_ST_PERMIT 0
`define BGA_ST_PEND 1
`define BGA_ST_WON 2
`define BGA_ST_LOST 3
`define BGA_ST_ABAND 4
`define BGA_ST_REFUSE 5
`define BGA_ST_ACKGAP 6
`define BGA_ST_SUBGAP 7
`define BGA_ST_ARSTGAP 8
`define BGA_ST_STATE_LSB 9

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BGA_NID_RST 6'h00
`define BGA_PRIO_RST 4'h1
`define BGA_PERMIT_RST 1'b1

// ----------------------------------------------------------------
// request kinds and reserved priorities
// ----------------------------------------------------------------
`define BGA_KIND_ACK 2'h0
`define BGA_KIND_FAIR 2'h1
`define BGA_KIND_URG 2'h2
`define BGA_KIND_CYC 2'h3
`define BGA_PRIO_FAIR 4'h0
`define BGA_PRIO_CYC 4'hf

// ----------------------------------------------------------------
// gap counts in arbitration clock periods, and the index of the last sequence bit
// ----------------------------------------------------------------
`define BGA_ACK_DET 6'h04
`define BGA_ACK_DRV 6'h08
`define BGA_SUB_DET 6'h10
`define BGA_SUB_DRV 6'h14
`define BGA_ARST_DET 6'h1c
`define BGA_ARST_DRV 6'h20
`define BGA_SEQ_LAST 4'h9

`endif

// File: bga_arbiter_props.sv
// assertion checker on the ports of the backplane gap arbiter
`timescale 1ns/100ps
`default_nettype none
module bga_arbiter_props (
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   input wire rx_data_i,
   input wire rx_strb_i,
   input wire tx_data_o,
   input wire tx_data_oe_n_o,
   input wire bus_won_o
);
   // ------------------------------------------------------------
   // run lengths
   // ------------------------------------------------------------
   reg [5:0] idle_q;
   reg [3:0] hi_q;
   wire busy = rx_data_i | rx_strb_i;
   // idle ticks of the bus and released cycles of the own drive
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         idle_q <= 6'h00;
         hi_q <= 4'h0;
      end else begin
         idle_q <= busy ? 6'h00 : idle_q + {5'h00, idle_q != 6'h20};
         hi_q <= !tx_data_oe_n_o ? 4'h0 : hi_q + {3'h0, hi_q != 4'hf};
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   a_gap_before_drive:
   assert property (!tx_data_oe_n_o && hi_q > 4'h9 |-> idle_q > 6'h07)
      else $error("drive began before an ack gap");
   a_idle_both_low:
   assert property (!tx_data_oe_n_o && hi_q > 4'h9 |-> !$past(busy))
      else $error("drive began after a busy cycle");
   a_owner_asserts:
   assert property (bus_won_o |-> !tx_data_oe_n_o && rx_data_i)
      else $error("owner not asserting the bus");
   a_assert_is_one:
   assert property (!tx_data_oe_n_o |-> tx_data_o)
      else $error("driven level is not one");
   a_own_stands:
   assert property ($rose(bus_won_o) |=> bus_won_o [*2])
      else $error("ownership dropped early");
   a_ready_wait:
   assert property (psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o)
      else $error("ready not after one wait state");
   a_ready_pulse:
   assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_err_unmapped:
   assert property (pready_o && paddr_i > 8'h0c |-> pslverr_o)
      else $error("no error on unmapped address");
   a_ok_mapped:
   assert property (pready_o && paddr_i < 8'h0d && paddr_i[1:0] == 2'h0
      |-> !pslverr_o)
      else $error("error on mapped address");
   a_err_reads_zero:
   assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 0)
      else $error("refused read not zero");
endmodule // bga_arbiter_props
bind bga_arbiter bga_arbiter_props u_props (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .rx_data_i(rx_data_i), .rx_strb_i(rx_strb_i),
   .tx_data_o(tx_data_o), .tx_data_oe_n_o(tx_data_oe_n_o),
   .bus_won_o(bus_won_o)
);
`default_nettype wire

// File: bga_peer.sv
// behavioural model of another node on the shared backplane bus
`timescale 1ns/100ps
`default_nettype none
module bga_peer (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic rx_data_i,
   input wire logic rx_strb_i,
   input wire logic busy_i,
   input wire logic arb_i,
   input wire logic [9:0] seq_i,
   output logic drv_o,
   output logic strb_o
);
   // ------------------------------------------------------------
   // gap timing and contest
   // ------------------------------------------------------------
   logic [5:0] idle_q;
   logic [3:0] bit_q;
   logic act_q;
   logic tog_q;
   wire idle = !rx_data_i && !rx_strb_i;
   // count idle ticks, start at the subaction drive point, drop on loss
   always @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         idle_q <= 6'h00;
         bit_q <= 4'h0;
         act_q <= 1'b0;
         tog_q <= 1'b0;
      end else begin
         idle_q <= idle ? idle_q + {5'h00, idle_q != 6'h20} : 6'h00;
         tog_q <= !tog_q;
         if (act_q) begin
            bit_q <= bit_q - 4'h1;
            act_q <= bit_q != 4'h0 && !(!seq_i[bit_q] && rx_data_i);
         end else if (arb_i && idle && idle_q == 6'h13) begin
            act_q <= 1'b1;
            bit_q <= 4'h9;
         end
      end
   end
   // packet traffic flips both lines every cycle; contest bits msb first
   assign drv_o = busy_i ? tog_q : act_q && seq_i[bit_q];
   assign strb_o = busy_i && !tog_q;
endmodule // bga_peer
`default_nettype wire

// File: backplane_gap_arbitration_tb_top.sv
// self-checking bench of the backplane gap arbiter
`timescale 1ns/100ps
`default_nettype none
`include "bga_regs.vh"
module backplane_gap_arbitration_tb_top;
   // ------------------------------------------------------------
   // signals and models
   // ------------------------------------------------------------
   typedef struct {string n; logic [31:0] e; logic [31:0] m;
      logic r;} bga_note_t;
   logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0;
   logic penable_i = 1'b0, pwrite_i = 1'b0, busy = 1'b0, arb = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o;
   logic pready_o, pslverr_o, tx_data_o, tx_data_oe_n_o, bus_won_o;
   logic peer_drv, peer_strb;
   logic [9:0] peer_seq = 10'h000, s;
   logic [5:0] nid, cnt = 6'h00;
   logic [3:0] pr, ep;
   logic [31:0] cmd [5] = '{32'h15, 32'h6, 32'h7, 32'h5, 32'h5};
   logic [5:0] thr [5] = '{6'h14, 6'h14, 6'h14, 6'h14, 6'h20};
   int n_fail = 0, checks = 0;
   bga_note_t q[$];
   wire rx_data = !tx_data_oe_n_o | peer_drv; // wired-or
   always #25 clk_sys_i = !clk_sys_i;
   bga_arbiter u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_data_i(rx_data),
      .rx_strb_i(peer_strb), .tx_data_o(tx_data_o),
      .tx_data_oe_n_o(tx_data_oe_n_o), .bus_won_o(bus_won_o));
   bga_peer u_peer (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .rx_data_i(rx_data), .rx_strb_i(peer_strb), .busy_i(busy),
      .arb_i(arb), .seq_i(peer_seq), .drv_o(peer_drv), .strb_o(peer_strb));
   // idle tick count of the bus as the bench sees it
   always @(posedge clk_sys_i) begin
      cnt <= (sys_rst_i | rx_data | peer_strb) ? 6'h00 :
         cnt + {5'h00, cnt != 6'h20};
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task chk(input string n, input logic [31:0] e, input logic [31:0] v);
      checks++;
      if (v !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, v);
      end
   endtask
   task print_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task to_out;
      n_fail++;
      $display("wrong value wait expected done seen timeout");
      print_verdict();
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_sys_i);
         i++;
      end while (pready_o !== 1'b1 && i < 50);
      if (pready_o !== 1'b1) to_out();
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task rd(input string n, input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m, input logic r);
      q.push_back('{n, e, m, r});
      apb(1'b0, a, 32'h0);
   endtask
   task busy_pulse;
      @(posedge clk_sys_i);
      busy <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      busy <= 1'b0;
   endtask
   task wcnt(input logic [5:0] v);
      int i;
      #1;
      i = 0;
      while (cnt !== v && i < 300) begin
         @(posedge clk_sys_i);
         #1;
         i++;
      end
      if (i == 300) to_out();
   endtask
   task cap(input logic [5:0] v);
      wcnt(v);
      for (int k = 9; k >= 0; k--) begin
         s[k] = !tx_data_oe_n_o;
         @(posedge clk_sys_i);
         #1;
      end
   endtask
   // read answers are taken against the oldest note
   always @(posedge clk_sys_i) begin
      if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i
         && q.size() > 0) begin
         chk({q[0].n, " data"}, q[0].e, prdata_o & q[0].m);
         chk({q[0].n, " error"}, {31'h0, q[0].r}, {31'h0, pslverr_o});
         void'(q.pop_front());
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h1e26));
      nid = 6'($urandom % 63);
      pr = 4'($urandom % 14 + 1);
      repeat (5) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      rd("ctrl", `BGA_CTRL_OFF, 32'h40, 32'h3ff, 1'b0);
      rd("status", `BGA_STAT_OFF, 32'h1, 32'h3f, 1'b0);
      rd("unmapped", 8'h10, 32'h0, 32'hffffffff, 1'b1);
      apb(1'b1, `BGA_CTRL_OFF, {22'h0, pr, nid});
      rd("ctrl", `BGA_CTRL_OFF, {22'h0, pr, nid}, 32'h3ff, 1'b0);
      $display("test registers done");
      for (int t = 0; t < 5; t++) begin
         busy_pulse();
         apb(1'b1, `BGA_CMD_OFF, cmd[t]);
         cap(thr[t]);
         ep = cmd[t][1:0] == 2'h1 ? 4'h0 : cmd[t][1:0] == 2'h2 ? pr : 4'hf;
         chk("sequence", {22'h0, ep, nid}, {22'h0, s});
         chk("won", 32'h1, {31'h0, bus_won_o});
         rd("status", `BGA_STAT_OFF, {31'h2, t < 3}, 32'h5, 1'b0);
         apb(1'b1, `BGA_CMD_OFF, 32'h8);
         apb(1'b1, `BGA_STAT_OFF, 32'h3c);
         $display("test arbitration %0d done", t);
      end
      busy_pulse();
      apb(1'b1, `BGA_CMD_OFF, 32'h4);
      cap(6'h08);
      chk("ack drive", 32'h3ff, {22'h0, s});
      chk("ack won", 32'h1, {31'h0, bus_won_o});
      chk("ack level", 32'h1, {31'h0, tx_data_o});
      apb(1'b1, `BGA_CMD_OFF, 32'h8);
      apb(1'b1, `BGA_STAT_OFF, 32'h3c);
      $display("test acknowledge done");
      pr = 4'($urandom % 14 + 1);
      apb(1'b1, `BGA_CTRL_OFF, {22'h0, pr, nid});
      peer_seq <= {pr, 6'h3f};
      arb <= 1'b1;
      busy_pulse();
      apb(1'b1, `BGA_CMD_OFF, 32'h6);
      cap(6'h14);
      chk("lost won", 32'h0, {31'h0, bus_won_o});
      rd("status", `BGA_STAT_OFF, 32'h8, 32'hc, 1'b0);
      apb(1'b1, `BGA_CMD_OFF, 32'h20);
      arb <= 1'b0;
      apb(1'b1, `BGA_STAT_OFF, 32'h3c);
      $display("test contest lost done");
      busy_pulse();
      apb(1'b1, `BGA_CMD_OFF, 32'h5);
      wcnt(6'h0a);
      apb(1'b1, `BGA_CMD_OFF, 32'h6);
      busy_pulse();
      rd("status", `BGA_STAT_OFF, 32'h30, 32'h30, 1'b0);
      cap(6'h20);
      chk("retry", {22'h0, 4'h0, nid}, {22'h0, s});
      apb(1'b1, `BGA_CMD_OFF, 32'h8);
      $display("test abandon done");
      chk("notes left", 32'h0, q.size());
      print_verdict();
   end
endmodule // backplane_gap_arbitration_tb_top
`default_nettype wire
